// ==== tpd_defines.svh ====
/*
 * Offsets, field positions, reset values and scale constants of the
 * tap pulse detector register block.
 * Assumes word-aligned registers on a 32-bit bus, byte address = 4 * index.
 */
// What this block does
// - abort bit clear: latency pulse never aborts
// - abort bit set: short latency pulse aborts
// - latch enabled: flags frozen until source read
// - per-axis enable for double-pulse events
// - per-axis enable for single-pulse events
// - summary active bit set by enabled events
// - one event bit per axis
// - status bit tells double from single
// - per-axis polarity bit, one means negative
// - per-axis 7-bit threshold, 0.063 g steps
// - thresholds always on 8 g scale
// - threshold crossing starts pulse detection
// - latency after first pulse ignores new starts
`ifndef TPD_DEFINES_SVH
`define TPD_DEFINES_SVH

// register indices
`define TPD_IDX_CONFIG  8'h21
`define TPD_IDX_SOURCE  8'h22
`define TPD_IDX_THS_X   8'h23
`define TPD_IDX_THS_Y   8'h24
`define TPD_IDX_THS_Z   8'h25
`define TPD_IDX_LATENCY 8'h27

// config fields; axis a uses bit 2a (single) and 2a+1 (double)
`define TPD_CFG_DPA 7
`define TPD_CFG_ELE 6

// source fields; axis a event at AX0+a, polarity at POL0+a
`define TPD_SRC_EA   7
`define TPD_SRC_AX0  4
`define TPD_SRC_DPE  3
`define TPD_SRC_POL0 0

// reset values
`define TPD_CFG_RST 8'h00
`define TPD_SRC_RST 8'h00
`define TPD_THS_RST 7'h00
`define TPD_LAT_RST 8'h00

// one threshold step is 64 counts of a 14-bit 8 g sample
`define TPD_THS_SHIFT 6
`define TPD_FS_8G     2'h2
`define TPD_DP_WINDOW 8'hFF

`endif

// ==== tpd_pkg.sv ====
/*
 * Types of the tap pulse detector: axis state machine and state records.
 * Assumes nothing of its surroundings.
 */
package tpd_pkg;

	typedef enum logic [4:0] {
		AX_IDLE   = 5'h01,
		AX_FIRST  = 5'h02,
		AX_LAT    = 5'h04,
		AX_WIN    = 5'h08,
		AX_SECOND = 5'h10
	} tpd_axis_fsm_t;

	typedef struct packed {
		tpd_axis_fsm_t fsm;
		logic [7:0]    cnt;
		logic          lat_pulse;
		logic          pol;
		logic          single;
		logic          dbl;
	} tpd_axis_state_t;

	typedef struct packed {
		logic [7:0]      cfg;
		logic [2:0][6:0] ths;
		logic [7:0]      lat;
		logic [7:0]      src;
		logic            wr_pend;
		logic [7:0]      wr_idx;
		logic [31:0]     rdata;
		logic            ready;
		logic            resp;
	} tpd_regs_state_t;

endpackage

// ==== tpd_axis.sv ====
/*
 * One axis of the tap detector: threshold compare on a fixed 8 g scale,
 * single/double pulse sequencing with a latency interval.
 * Assumes samples arrive with a one-cycle sample_tick_i strobe.
 */
`timescale 1ns/1ns
`include "tpd_defines.svh"

module tpd_axis #(
	parameter int         SAMPLE_W     = 14,
	parameter logic [7:0] WINDOW_TICKS = `TPD_DP_WINDOW
) (
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       reset_i,
	// sample
	input  wire logic                       sample_tick_i,
	input  wire logic signed [SAMPLE_W-1:0] accel_i,
	input  wire logic [1:0]                 fs_i,
	// settings
	input  wire logic [6:0]                 ths_i,
	input  wire logic [7:0]                 latency_i,
	input  wire logic                       dpa_i,
	// events
	output logic                            single_o,
	output logic                            double_o,
	output logic                            pol_o
);
	localparam int MW = SAMPLE_W + 1;

	tpd_pkg::tpd_axis_state_t s_q, s_d;
	logic [MW-1:0]        mag;
	logic                 above;
	logic                 neg;

	// rescale to 8 g counts whatever range is selected
	// magnitude before the shift, so both signs round alike
	always_comb begin
		neg = accel_i[SAMPLE_W-1];
		mag = neg ? MW'(-MW'(accel_i)) : MW'(accel_i);
		if (fs_i == 2'h0)
			mag = mag >> 2;
		else if (fs_i == 2'h1)
			mag = mag >> 1;
	end
	assign above = mag > MW'({ths_i, 6'h00});

	always_comb begin
		s_d        = s_q;
		s_d.single = 1'b0;
		s_d.dbl    = 1'b0;
		if (sample_tick_i) begin
			unique case (s_q.fsm)
				tpd_pkg::AX_IDLE: if (above) begin
					s_d.fsm = tpd_pkg::AX_FIRST;
					s_d.pol = neg;
				end
				tpd_pkg::AX_FIRST: if (!above) begin
					s_d.single    = 1'b1;
					s_d.fsm       = tpd_pkg::AX_LAT;
					s_d.cnt       = latency_i;
					s_d.lat_pulse = 1'b0;
				end
				tpd_pkg::AX_LAT: begin
					if (above)
						s_d.lat_pulse = 1'b1; // start ignored
					if (s_q.lat_pulse && !above && dpa_i && s_q.cnt != 8'h00)
						s_d.fsm = tpd_pkg::AX_IDLE;
					else if (s_q.cnt == 8'h00) begin
						s_d.fsm = tpd_pkg::AX_WIN;
						s_d.cnt = WINDOW_TICKS;
					end else
						s_d.cnt = s_q.cnt - 8'h01;
				end
				tpd_pkg::AX_WIN: begin
					// a pulse still running from the latency is not a new start
					if (!above)
						s_d.lat_pulse = 1'b0;
					if (above && !s_q.lat_pulse) begin
						s_d.fsm = tpd_pkg::AX_SECOND;
						s_d.pol = neg;
					end else if (s_q.cnt == 8'h00)
						s_d.fsm = tpd_pkg::AX_IDLE;
					else
						s_d.cnt = s_q.cnt - 8'h01;
				end
				tpd_pkg::AX_SECOND: if (!above) begin
					s_d.dbl = 1'b1;
					s_d.fsm = tpd_pkg::AX_IDLE;
				end
				default: s_d.fsm = tpd_pkg::AX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			s_q <= '{fsm: tpd_pkg::AX_IDLE, default: '0};
		else
			s_q <= s_d;
	end

	assign single_o = s_q.single;
	assign double_o = s_q.dbl;
	assign pol_o    = s_q.pol;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	property p_start;
		sample_tick_i && s_q.fsm == tpd_pkg::AX_IDLE && above
			|=> s_q.fsm == tpd_pkg::AX_FIRST && s_q.pol == $past(neg);
	endproperty
	a_start: assert property (p_start) else $error("crossing did not start pulse");

	sequence s_short_lat_pulse;
		sample_tick_i && s_q.fsm == tpd_pkg::AX_LAT && s_q.lat_pulse && !above
			&& s_q.cnt != 8'h00;
	endsequence
	property p_abort;
		(s_short_lat_pulse and dpa_i) |=> s_q.fsm == tpd_pkg::AX_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("double pulse not aborted");
	property p_keep;
		(s_short_lat_pulse and !dpa_i) |=> s_q.fsm == tpd_pkg::AX_LAT
			&& s_q.cnt == $past(s_q.cnt) - 8'h01;
	endproperty
	a_keep: assert property (p_keep) else $error("double pulse wrongly aborted");
	property p_lat_len;
		s_q.single |-> s_q.fsm == tpd_pkg::AX_LAT && s_q.cnt == $past(latency_i);
	endproperty
	a_lat_len: assert property (p_lat_len) else $error("latency not loaded");

endmodule // tpd_axis

// ==== tpd_regs.sv ====
/*
 * Tap pulse detector register block: AHB-Lite slave with config,
 * source, per-axis threshold and latency registers, and three axis
 * detectors feeding the source status.
 * Assumes single word transfers and synchronous sample inputs.
 */
`timescale 1ns/1ns
`include "tpd_defines.svh"

module tpd_regs #(
	parameter int         SAMPLE_W     = 14,
	parameter logic [7:0] WINDOW_TICKS = `TPD_DP_WINDOW
) (
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       reset_i,
	// ahb-lite slave
	input  wire logic                       hsel_i,
	input  wire logic [31:0]                haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [31:0]                hwdata_i,
	input  wire logic                       hready_i,
	output logic      [31:0]                hrdata_o,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	// acceleration samples
	input  wire logic                       sample_tick_i,
	input  wire logic signed [SAMPLE_W-1:0] accel_x_i,
	input  wire logic signed [SAMPLE_W-1:0] accel_y_i,
	input  wire logic signed [SAMPLE_W-1:0] accel_z_i,
	input  wire logic [1:0]                 full_scale_select_i,
	// status
	output logic                            tap_event_active_o
);

	tpd_pkg::tpd_regs_state_t s_q, s_d;

	logic signed [2:0][SAMPLE_W-1:0] accel;
	logic [2:0] single;
	logic [2:0] dbl;
	logic [2:0] pol;
	logic [2:0] ev;
	logic [2:0] sp_en;
	logic [2:0] dp_en;
	logic       any_ev;
	logic       dbl_ev;
	logic       accept;
	logic [7:0] idx;
	logic       rd_src;
	logic       frozen;

	// word index of a byte address; upper bits must be zero
	function automatic logic [7:0] word_idx(input logic [31:0] a);
		word_idx = (a[31:10] == 22'h0) ? a[9:2] : 8'h00;
	endfunction

	// true for an index that holds a register
	function automatic logic is_mapped(input logic [7:0] i);
		is_mapped = (i == `TPD_IDX_CONFIG) || (i == `TPD_IDX_SOURCE)
			|| (i == `TPD_IDX_THS_X) || (i == `TPD_IDX_THS_Y)
			|| (i == `TPD_IDX_THS_Z) || (i == `TPD_IDX_LATENCY);
	endfunction

	assign accel[0] = accel_x_i;
	assign accel[1] = accel_y_i;
	assign accel[2] = accel_z_i;

	generate
		for (genvar a = 0; a < 3; a++) begin : g_axis
			assign sp_en[a] = s_q.cfg[2*a];
			assign dp_en[a] = s_q.cfg[2*a+1];
			// only enabled event kinds reach the source register
			assign ev[a] = (single[a] && sp_en[a])
				|| (dbl[a] && dp_en[a]);

			tpd_axis #(
				.SAMPLE_W     (SAMPLE_W),
				.WINDOW_TICKS (WINDOW_TICKS)
			) u_axis (
				.core_clk_i    (core_clk_i),
				.reset_i       (reset_i),
				.sample_tick_i (sample_tick_i),
				.accel_i       (accel[a]),
				.fs_i          (full_scale_select_i),
				.ths_i         (s_q.ths[a]),
				.latency_i     (s_q.lat),
				.dpa_i         (s_q.cfg[`TPD_CFG_DPA]),
				.single_o      (single[a]),
				.double_o      (dbl[a]),
				.pol_o         (pol[a])
			);
		end
	endgenerate

	assign any_ev = |ev;
	assign dbl_ev = |(dbl & dp_en);
	assign accept = hsel_i && htrans_i[1] && hready_i;
	assign idx    = word_idx(haddr_i);
	assign rd_src = accept && !hwrite_i && idx == `TPD_IDX_SOURCE;
	// latched contents stay put until the host reads them
	assign frozen = s_q.cfg[`TPD_CFG_ELE] && s_q.src[`TPD_SRC_EA] && !rd_src;

	always_comb begin
		s_d       = s_q;
		s_d.ready = 1'b1;
		s_d.resp  = 1'b0;

		// write data phase lands before the read mux, so a read right
		// after a write returns the new value
		if (s_q.wr_pend) begin
			unique case (s_q.wr_idx)
				`TPD_IDX_CONFIG:  s_d.cfg    = hwdata_i[7:0];
				`TPD_IDX_THS_X:   s_d.ths[0] = hwdata_i[6:0];
				`TPD_IDX_THS_Y:   s_d.ths[1] = hwdata_i[6:0];
				`TPD_IDX_THS_Z:   s_d.ths[2] = hwdata_i[6:0];
				`TPD_IDX_LATENCY: s_d.lat    = hwdata_i[7:0];
				default:          s_d.lat    = s_q.lat;
			endcase
		end
		s_d.wr_pend = accept && hwrite_i && is_mapped(idx);
		s_d.wr_idx  = idx;

		// read clear first, so an event in the same cycle survives
		if (rd_src)
			s_d.src = `TPD_SRC_RST;
		if (any_ev && !frozen) begin
			s_d.src[`TPD_SRC_EA] = 1'b1;
			s_d.src[`TPD_SRC_DPE] = dbl_ev;
			for (int a = 0; a < 3; a++) begin
				s_d.src[`TPD_SRC_AX0+a]  = ev[a];
				s_d.src[`TPD_SRC_POL0+a] = ev[a] && pol[a];
			end
		end

		if (accept && !hwrite_i) begin
			unique case (idx)
				`TPD_IDX_CONFIG:  s_d.rdata = {24'h0, s_d.cfg};
				`TPD_IDX_SOURCE:  s_d.rdata = {24'h0, s_q.src};
				`TPD_IDX_THS_X:   s_d.rdata = {25'h0, s_d.ths[0]};
				`TPD_IDX_THS_Y:   s_d.rdata = {25'h0, s_d.ths[1]};
				`TPD_IDX_THS_Z:   s_d.rdata = {25'h0, s_d.ths[2]};
				`TPD_IDX_LATENCY: s_d.rdata = {24'h0, s_d.lat};
				default:          s_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i)
			s_q <= '{cfg: `TPD_CFG_RST, ths: {3{`TPD_THS_RST}},
				lat: `TPD_LAT_RST, src: `TPD_SRC_RST, default: '0};
		else
			s_q <= s_d;
	end

	assign hrdata_o           = s_q.rdata;
	assign hreadyout_o        = s_q.ready;
	assign hresp_o            = s_q.resp;
	assign tap_event_active_o = s_q.src[`TPD_SRC_EA];

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	property p_hold;
		frozen |=> s_q.src == $past(s_q.src);
	endproperty
	a_hold: assert property (p_hold) else $error("latched source changed");

	sequence s_src_read;
		rd_src && !any_ev;
	endsequence
	property p_read_clear;
		s_src_read |=> s_q.src == 8'h00 && hrdata_o[7:0] == $past(s_q.src);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");

	property p_update;
		any_ev && !s_q.cfg[`TPD_CFG_ELE]
			|=> s_q.src[6:4] == $past(ev) && s_q.src[`TPD_SRC_EA];
	endproperty
	a_update: assert property (p_update) else $error("source not updated");

	property p_active;
		s_q.src[6:4] != 3'h0 |-> tap_event_active_o;
	endproperty
	a_active: assert property (p_active) else $error("active bit missing");

	property p_dp_en;
		dbl[0] && dp_en[0] && !frozen
			|=> s_q.src[`TPD_SRC_AX0] && s_q.src[`TPD_SRC_DPE];
	endproperty
	a_dp_en: assert property (p_dp_en) else $error("double pulse lost");

	property p_sp_off;
		!s_q.src[`TPD_SRC_EA] && !rd_src && (single & sp_en) == 3'h0
			&& (dbl & dp_en) == 3'h0 |=> !s_q.src[`TPD_SRC_EA];
	endproperty
	a_sp_off: assert property (p_sp_off) else $error("disabled event flagged");

	property p_pol;
		ev[1] && !frozen |=> s_q.src[`TPD_SRC_POL0+1] == $past(pol[1]);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity wrong");

	property p_axis;
		ev[2] && !frozen |=> s_q.src[`TPD_SRC_AX0+2];
	endproperty
	a_axis: assert property (p_axis) else $error("axis bit missing");

	property p_ths_write;
		s_q.wr_pend && s_q.wr_idx == `TPD_IDX_THS_Y |=> s_q.ths[1] == $past(hwdata_i[6:0]);
	endproperty
	a_ths_write: assert property (p_ths_write) else $error("threshold write lost");

	// ready rises at the first edge after release, so that edge still sees 0
	property p_okay;
		hresp_o == 1'b0 && (hreadyout_o || $past(reset_i));
	endproperty
	a_okay: assert property (p_okay) else $error("bad bus response");

endmodule // tpd_regs

// ==== tpd_host_model.sv ====
/*
 * Host processor model: an AHB-Lite master doing single word transfers.
 * Assumes one slave whose hreadyout is fed back as the bus hready.
 */
`timescale 1ns/1ns
module tpd_host_model (
	// clock
	input  wire logic        core_clk_i,
	// bus
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_i,
	output logic             hsel_o,
	output logic [31:0]      haddr_o,
	output logic [1:0]       htrans_o,
	output logic             hwrite_o,
	output logic [2:0]       hsize_o,
	output logic [31:0]      hwdata_o
);
	int tmo = 0;
	// select stays high: idle cycles are marked by htrans alone
	initial begin
		hsel_o = 1'b1;
		haddr_o = 32'h0000_0000;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = 3'h2;
		hwdata_o = 32'h0000_0000;
	end
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 64);
		if (hready_i !== 1'b1) tmo++;
	endtask
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		htrans_o <= 2'h2;
		haddr_o <= a;
		hwrite_o <= wr;
		hsize_o <= 3'h2;
		wait_rdy();
		htrans_o <= 2'h0;
		hwdata_o <= wr ? wd : ~hwdata_o;
		wait_rdy();
		rd = hrdata_i;
		// released data lines must not keep looking valid
		hwdata_o <= ~hwdata_o;
	endtask
endmodule // tpd_host_model

// ==== test_tap_pulse_detect_regs.sv ====
/*
 * Self-checking bench of the tap detector registers: random single pulses,
 * latch modes, double pulses with and without abort.
 * Assumes the host model file and the design files are compiled first.
 */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
$display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module test_tap_pulse_detect_regs;
	localparam logic [31:0] A_CFG = 32'h0000_0084;
	localparam logic [31:0] A_SRC = 32'h0000_0088;
	localparam logic [31:0] A_THS = 32'h0000_008C;
	localparam logic [31:0] A_LAT = 32'h0000_009C;
	localparam logic [31:0] A_NONE = 32'h0000_00A0;
	logic              core_clk_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              sample_tick_i = 1'b0;
	logic signed [13:0] acc [3] = '{14'sh0000, 14'sh0000, 14'sh0000};
	logic [1:0]        fs = 2'h2;
	logic              hsel, hwrite, hready, hresp, active;
	logic [31:0]       haddr, hwdata, hrdata, rd;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	int                n_mismatch = 0;
	int                check_count = 0;

	always #50 core_clk_i = ~core_clk_i;

	tpd_host_model tpd_host_model_i (.core_clk_i(core_clk_i), .hready_i(hready),
		.hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
		.hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

	tpd_regs #(.SAMPLE_W(14), .WINDOW_TICKS(8'h04)) tpd_regs_i (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.sample_tick_i(sample_tick_i), .accel_x_i(acc[0]), .accel_y_i(acc[1]),
		.accel_z_i(acc[2]), .full_scale_select_i(fs), .tap_event_active_o(active));

	task automatic rw(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		tpd_host_model_i.xfer(wr, a, wd, rd);
		if (tpd_host_model_i.tmo != 0)
			summarize();
	endtask
	task automatic chk_reg(input string nm, input logic [31:0] a, input logic [31:0] e);
		rw(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rd)
	endtask
	// one sample on axis a, the others at rest
	task automatic tk(input int a, input logic signed [13:0] v);
		for (int i = 0; i < 3; i++) acc[i] <= (i == a) ? v : 14'sh0000;
		sample_tick_i <= 1'b1;
		@(posedge core_clk_i);
		sample_tick_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask
	task automatic idle(input int n);
		repeat (n) tk(0, 14'sh0000);
	endtask
	task automatic pulse(input int a, input logic signed [13:0] v);
		tk(a, v);
		tk(a, 14'sh0000);
	endtask
	function automatic logic [7:0] src_exp(bit en, int a, bit neg, bit dbl);
		return en ? (8'h80 | (8'h10 << a) | {4'h0, dbl, 3'h0} | (8'(neg) << a)) : 8'h00;
	endfunction
	// magnitude rescaled to 8 g counts against 64 counts per step
	function automatic bit over(logic [13:0] m, logic [1:0] f, logic [6:0] t);
		int s;
		s = (f == 2'h0) ? m / 4 : (f == 2'h1) ? m / 2 : m;
		return s > t * 64;
	endfunction

	task automatic summarize();
		n_mismatch += tpd_host_model_i.tmo;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#4000000;
		n_mismatch++;
		summarize();
	end

	initial begin
		logic [31:0] addrs [6];
		logic [7:0]  cfg, th, e;
		logic [13:0] m;
		int          a;
		bit          neg;
		addrs = '{A_CFG, A_SRC, A_THS, A_THS + 4, A_THS + 8, A_LAT};
		void'($urandom(25));
		repeat (5) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		foreach (addrs[i]) chk_reg("reset", addrs[i], 32'h0000_0000);
		rw(1'b1, A_NONE, 32'hFFFF_FFFF);
		chk_reg("unmapped", A_NONE, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			th = $urandom;
			rw(1'b1, A_THS + 4 * i, {24'h0, th});
			chk_reg("threshold", A_THS + 4 * i, {25'h0, th[6:0]});
			rw(1'b1, A_THS + 4 * i, 32'h0000_0004);
		end
		// random single pulses across ranges and enables
		repeat (16) begin
			cfg = $urandom;
			cfg[7:6] = 2'h1;
			a = $urandom_range(2);
			neg = $urandom;
			m = 14'($urandom_range(900, 200));
			fs <= 2'($urandom);
			rw(1'b1, A_CFG, {24'h0, cfg});
			pulse(a, neg ? -m : m);
			e = src_exp(cfg[2 * a] && over(m, fs, 7'h04), a, neg, 1'b0);
			`CHK("active", e[7], active)
			chk_reg("source", A_SRC, {24'h0, e});
			chk_reg("cleared", A_SRC, 32'h0000_0000);
			idle(10);
		end
		fs <= 2'h2;
		// a later event kept out by latch, let in without it
		for (int l = 0; l < 2; l++) begin
			rw(1'b1, A_CFG, 32'h0000_0015 | (l << 6));
			pulse(0, 14'sh0258);
			idle(10);
			pulse(1, -14'sh0258);
			idle(2);
			e = l ? src_exp(1, 0, 0, 0) : src_exp(1, 1, 1, 0);
			chk_reg("latch", A_SRC, {24'h0, e});
		end
		// pulse inside latency, then a fresh one in the window
		rw(1'b1, A_LAT, 32'h0000_0004);
		for (int l = 0; l < 2; l++) begin
			rw(1'b1, A_CFG, 32'h0000_0042 | (l << 7));
			pulse(0, 14'sh0258);
			pulse(0, 14'sh0258);
			idle(4);
			pulse(0, 14'sh0258);
			idle(2);
			e = l ? 8'h00 : src_exp(1, 0, 0, 1);
			chk_reg("double", A_SRC, {24'h0, e});
			idle(10);
		end
		summarize();
	end
endmodule // test_tap_pulse_detect_regs
